// ==== ceau_checker_sva.sv ====
// Checker of the effective-address unit: timing and value relations at its ports.
// Assumes it is bound to ceau_top and sees only the ports of that module.
`timescale 1ns/1ns
module ceau_checker #(
   parameter int AW = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Decoded request
   input wire logic i_req,
   input wire ceau_pkg::ceau_class_t i_class,
   input wire ceau_pkg::ceau_mode_t i_mode,
   input wire logic [7:0] i_byte2,
   input wire logic [15:0] i_word2,
   input wire logic i_small_two,
   input wire logic [15:0] i_pc,
   // Memory port
   input wire logic i_mem_rvalid,
   input wire logic [15:0] i_mem_rdata,
   input wire logic o_mem_rd,
   input wire logic [AW-1:0] o_mem_addr,
   // Result
   input wire logic o_done,
   input wire logic o_illegal,
   input wire logic o_is_target,
   input wire logic [AW-1:0] o_ea,
   input wire logic [15:0] o_operand
);
   import ceau_pkg::*;
   // ------------------------------------------------------------
   // Relations
   // ------------------------------------------------------------
   logic [15:0] rel_sum;
   // The sum is formed here so that the property only samples it.
   assign rel_sum = i_pc + {{8{i_byte2[7]}}, i_byte2};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_done_next: assert property (i_req && i_mode != AM_MEM_IND |=> o_done)
      else $error("no result one cycle after request");
   a_short_abs: assert property (i_req && i_mode == AM_ABS8
      |=> o_ea == {ABS8_PAGE, $past(i_byte2)}) else $error("short absolute page wrong");
   a_long_jump: assert property (i_req && i_class == IC_JUMP && i_mode == AM_ABS16
      |=> o_is_target && o_ea == ($past(i_word2) & 16'hFFFE)) else $error("jump target wrong");
   a_rel_branch: assert property (i_req && i_class == IC_BRANCH && i_mode == AM_PC_REL
      |=> o_ea == ($past(rel_sum) & 16'hFFFE)) else $error("branch target wrong");
   a_small_imm: assert property (i_req && i_mode == AM_SMALL_IMM
      |=> o_operand == ($past(i_small_two) ? SMALL_IMM_TWO : SMALL_IMM_ONE))
      else $error("small immediate wrong");
   a_fetch_addr: assert property (i_req && i_class == IC_JUMP && i_mode == AM_MEM_IND
      |=> o_mem_rd && o_mem_addr == {MEMIND_PAGE, $past(i_byte2) & 8'hFE})
      else $error("pointer fetch address wrong");
   a_fetch_target: assert property (i_mem_rvalid
      |=> o_done && o_is_target && o_ea == ($past(i_mem_rdata) & 16'hFFFE))
      else $error("fetched target wrong");
   a_alu_direct: assert property (i_req && i_class == IC_ALU_OTHER
      && i_mode != AM_REG_DIRECT |=> o_done && o_illegal) else $error("alu mode not refused");
   a_move_modes: assert property (i_req && i_mode inside {AM_PC_REL, AM_MEM_IND}
      && (i_class == IC_BYTE_MOVE || i_class == IC_WORD_MOVE) |=> o_illegal)
      else $error("move mode not refused");
   c_fetch: cover property (o_mem_rd);
   c_refused: cover property (o_done && o_illegal);
   c_target: cover property (o_done && o_is_target);
endmodule

bind ceau_top ceau_checker #(.AW(AW)) u_ceau_checker (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_class(i_class), .i_mode(i_mode),
   .i_byte2(i_byte2), .i_word2(i_word2), .i_small_two(i_small_two), .i_pc(i_pc),
   .i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd),
   .o_mem_addr(o_mem_addr), .o_done(o_done), .o_illegal(o_illegal),
   .o_is_target(o_is_target), .o_ea(o_ea), .o_operand(o_operand));

// ==== ceau_mode_check.sv ====
// Legality check: which addressing modes each instruction group accepts.
// Assumes the decoder presents group and mode in the same cycle.
`timescale 1ns/1ns
module ceau_mode_check (
   // Decoded instruction
   input wire ceau_pkg::ceau_class_t i_class,
   input wire ceau_pkg::ceau_mode_t i_mode,
   // Verdict
   output logic o_legal
);
   import ceau_pkg::*;

   always_comb begin
      o_legal = 1'b0;
      unique case (i_class)
         IC_BYTE_MOVE, IC_WORD_MOVE: begin
            // Moves take all modes but relative, memory indirect, both bit-number modes and small immediate.
            o_legal = !(i_mode inside {AM_PC_REL, AM_MEM_IND, AM_BIT_IMM3,
                                       AM_BIT_REG, AM_SMALL_IMM});
            // Short absolute is byte only, long immediate word only.
            if (i_class == IC_BYTE_MOVE && i_mode == AM_IMM16) begin
               o_legal = 1'b0;
            end
            if (i_class == IC_WORD_MOVE && i_mode inside {AM_ABS8, AM_IMM8}) begin
               o_legal = 1'b0;
            end
         end
         IC_PUSH: o_legal = (i_mode == AM_PRE_DEC);
         IC_POP: o_legal = (i_mode == AM_POST_INC);
         // Arithmetic uses register direct, some byte ops also immediate.
         IC_ALU_BYTE_IMM: o_legal = i_mode inside {AM_REG_DIRECT, AM_IMM8};
         IC_ALU_OTHER, IC_WORD_ALU: o_legal = (i_mode == AM_REG_DIRECT);
         IC_SMALL_ADDSUB: o_legal = (i_mode == AM_SMALL_IMM);
         // Bit ops: byte by direct, indirect or short absolute.
         IC_BIT_SCTT: o_legal = i_mode inside {AM_REG_DIRECT, AM_REG_INDIRECT, AM_ABS8,
                                               AM_BIT_IMM3, AM_BIT_REG};
         IC_BIT_OTHER: o_legal = i_mode inside {AM_REG_DIRECT, AM_REG_INDIRECT, AM_ABS8,
                                                AM_BIT_IMM3};
         IC_BRANCH: o_legal = (i_mode == AM_PC_REL);
         // Jumps take long absolute, memory indirect or register indirect.
         IC_JUMP: o_legal = i_mode inside {AM_ABS16, AM_MEM_IND, AM_REG_INDIRECT};
         default: o_legal = 1'b0;
      endcase
   end
endmodule

// ==== ceau_pkg.sv ====
// Package of the effective-address unit: mode, class and size encodings.
// Assumes a 16-bit address space and eight 16-bit general registers.
package ceau_pkg;
   localparam int ADDR_W = 16;
   localparam int REG_IDX_W = 3;
   localparam logic [2:0] STACK_PTR_IDX = 3'h7;
   localparam logic [7:0] ABS8_PAGE = 8'hFF;
   localparam logic [7:0] MEMIND_PAGE = 8'h00;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] SMALL_IMM_ONE = 16'h0001;
   localparam logic [15:0] SMALL_IMM_TWO = 16'h0002;

   // Addressing mode requested by the instruction decoder.
   typedef enum logic [3:0] {
      AM_REG_DIRECT,
      AM_REG_INDIRECT,
      AM_DISP16,
      AM_POST_INC,
      AM_PRE_DEC,
      AM_ABS8,
      AM_ABS16,
      AM_IMM8,
      AM_IMM16,
      AM_PC_REL,
      AM_MEM_IND,
      AM_BIT_IMM3,
      AM_BIT_REG,
      AM_SMALL_IMM
   } ceau_mode_t;

   // Instruction group, used to check which modes a group may use.
   typedef enum logic [3:0] {
      IC_BYTE_MOVE,
      IC_WORD_MOVE,
      IC_PUSH,
      IC_POP,
      IC_ALU_BYTE_IMM,
      IC_ALU_OTHER,
      IC_WORD_ALU,
      IC_SMALL_ADDSUB,
      IC_BIT_SCTT,
      IC_BIT_OTHER,
      IC_BRANCH,
      IC_JUMP
   } ceau_class_t;

   typedef enum logic {
      SZ_BYTE,
      SZ_WORD
   } ceau_size_t;
endpackage

// ==== ceau_regfile.sv ====
// General register file: eight 16-bit registers, two read ports, two writes.
// Assumes write port A (data) wins over port B (pointer update) on the same index.
`timescale 1ns/1ns
module ceau_regfile #(
   parameter int NREG = 8,
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Read ports
   input wire logic [2:0] i_ra_idx,
   input wire logic [2:0] i_rb_idx,
   output logic [DW-1:0] o_ra_data,
   output logic [DW-1:0] o_rb_data,
   // Write port A, data results
   input wire logic i_wa_en,
   input wire logic [2:0] i_wa_idx,
   input wire logic [DW-1:0] i_wa_data,
   // Write port B, address register updates
   input wire logic i_wb_en,
   input wire logic [2:0] i_wb_idx,
   input wire logic [DW-1:0] i_wb_data
);
   logic [DW-1:0] regs_reg [NREG];
   logic [DW-1:0] regs_next [NREG];

   assign o_ra_data = regs_reg[i_ra_idx];
   assign o_rb_data = regs_reg[i_rb_idx];

   always_comb begin
      for (int k = 0; k < NREG; k++) begin
         regs_next[k] = regs_reg[k];
      end
      if (i_wb_en) begin
         regs_next[i_wb_idx] = i_wb_data;
      end
      if (i_wa_en) begin
         regs_next[i_wa_idx] = i_wa_data;
      end
   end

   // The registers are not initialised by software semantics; reset to zero for X hygiene.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int k = 0; k < NREG; k++) begin
            regs_reg[k] <= '0;
         end
      end else begin
         for (int k = 0; k < NREG; k++) begin
            regs_reg[k] <= regs_next[k];
         end
      end
   end
endmodule

// ==== ceau_top.sv ====
// Effective-address unit: forms operand and branch addresses from the decoded
// mode, updates address registers and fetches memory-indirect targets.
// Assumes a single-cycle-request memory port with a read-data valid strobe.
//
// Functional notes
// - Register direct: byte register, word for listed ops.
// - Register indirect: address is whole 16-bit register.
// - Displacement mode adds 16-bit displacement to register.
// - Post-increment adds 1 or 2 after access.
// - Pre-decrement subtracts 1 or 2 before access.
// - Short absolute forces upper address byte ones.
// - Long absolute for moves, jump, subroutine jump.
// - Byte immediate byte two; word immediate bytes three-four.
// - Small add/subtract implies 1 or 2; bit number.
// - Relative branch adds sign-extended byte to PC.
// - Memory indirect reads word at zero-page address.
// - Odd word or branch address loses bit zero.
// - Arithmetic uses register direct, some byte immediate.
// - Moves use all but relative, memory indirect, bit-number, small immediate, long immediate for bytes, short absolute and byte immediate for words.
// - Bit ops: direct, indirect, short absolute; bit number.
// - Push is word pre-decrement store through stack pointer.
// - Pop is word post-increment load through stack pointer.
// - Register seven is the stack pointer.
`timescale 1ns/1ns
module ceau_top #(
   parameter int AW = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Decoded request
   input wire logic i_req,
   input wire ceau_pkg::ceau_class_t i_class,
   input wire ceau_pkg::ceau_mode_t i_mode,
   input wire ceau_pkg::ceau_size_t i_size,
   input wire logic [2:0] i_reg_idx,
   input wire logic i_reg_low,
   input wire logic [7:0] i_byte2,
   input wire logic [15:0] i_word2,
   input wire logic i_small_two,
   input wire logic i_bit_from_byte4,
   input wire logic [15:0] i_pc,
   // Register write from the execution unit
   input wire logic i_wr_en,
   input wire logic [2:0] i_wr_idx,
   input wire logic [15:0] i_wr_data,
   // Memory port for indirect fetches
   output logic o_mem_rd,
   output logic [AW-1:0] o_mem_addr,
   input wire logic i_mem_rvalid,
   input wire logic [15:0] i_mem_rdata,
   // Result
   output logic o_done,
   output logic o_illegal,
   output logic o_is_mem,
   output logic o_is_target,
   output logic [AW-1:0] o_ea,
   output logic [15:0] o_operand,
   output logic [2:0] o_bit_num
);
   import ceau_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} ceau_state_t;
   ceau_state_t state_reg, state_next;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Word alignment drops bit zero quietly, never flags an error.
   function automatic logic [15:0] ceau_align(input logic [15:0] a, input logic word);
      ceau_align = word ? {a[15:1], 1'b0} : a;
   endfunction

   function automatic logic [15:0] ceau_step(input ceau_size_t s);
      ceau_step = (s == SZ_WORD) ? STEP_WORD : STEP_BYTE;
   endfunction

   // -------------------------------------------------------------
   // Register file and legality
   // -------------------------------------------------------------
   logic [15:0] rd_a;
   logic [15:0] rd_b;
   logic legal;
   logic upd_en;
   logic [2:0] sel_idx;
   logic [15:0] upd_val;
   logic take;

   // A request counts only while idle; one that arrives during a pointer
   // fetch is dropped, so it must not step an address register either.
   assign take = i_req && legal && (state_reg == ST_IDLE);

   // Push and pop always address through register seven.
   assign sel_idx = (i_class inside {IC_PUSH, IC_POP}) ? STACK_PTR_IDX : i_reg_idx;

   ceau_regfile #(.NREG(8), .DW(16)) u_rf (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ra_idx(sel_idx),
      .i_rb_idx(i_reg_idx),
      .o_ra_data(rd_a),
      .o_rb_data(rd_b),
      .i_wa_en(i_wr_en),
      .i_wa_idx(i_wr_idx),
      .i_wa_data(i_wr_data),
      .i_wb_en(upd_en),
      .i_wb_idx(sel_idx),
      .i_wb_data(upd_val)
   );

   ceau_mode_check u_chk (
      .i_class(i_class),
      .i_mode(i_mode),
      .o_legal(legal)
   );

   // -------------------------------------------------------------
   // Address formation
   // -------------------------------------------------------------
   logic word_acc;
   logic [15:0] ea_c;
   logic [15:0] opnd_c;
   logic mem_c;
   logic tgt_c;
   logic fetch_c;
   logic [2:0] bit_c;
   logic [15:0] pc_sum;
   ceau_size_t eff_size;

   always_comb begin
      eff_size = (i_class inside {IC_PUSH, IC_POP}) ? SZ_WORD : i_size;
      word_acc = (eff_size == SZ_WORD);
      ea_c = '0;
      opnd_c = '0;
      mem_c = 1'b0;
      tgt_c = 1'b0;
      fetch_c = 1'b0;
      upd_en = 1'b0;
      upd_val = rd_a;
      bit_c = i_bit_from_byte4 ? i_word2[6:4] : i_byte2[6:4];
      // Sum truncates to 16 bits so relative targets wrap.
      pc_sum = 16'(i_pc + {{8{i_byte2[7]}}, i_byte2});
      unique case (i_mode)
         AM_REG_DIRECT: begin
            // Word operand only for the word-sized groups.
            if (i_class inside {IC_WORD_MOVE, IC_WORD_ALU, IC_SMALL_ADDSUB}) begin
               opnd_c = rd_a;
            end else begin
               opnd_c = {8'h00, i_reg_low ? rd_a[7:0] : rd_a[15:8]};
            end
         end
         AM_REG_INDIRECT: begin
            ea_c = ceau_align(rd_a, word_acc);
            mem_c = (i_class != IC_JUMP);
            tgt_c = (i_class == IC_JUMP);
            if (tgt_c) ea_c = ceau_align(rd_a, 1'b1);
         end
         AM_DISP16: begin
            ea_c = ceau_align(16'(rd_a + i_word2), word_acc);
            mem_c = 1'b1;
         end
         AM_POST_INC: begin
            // Access uses the old value, the register then steps up.
            ea_c = ceau_align(rd_a, word_acc);
            mem_c = 1'b1;
            upd_en = take;
            upd_val = 16'(rd_a + ceau_step(eff_size));
         end
         AM_PRE_DEC: begin
            // Register steps down first; the access uses the new value.
            upd_val = 16'(rd_a - ceau_step(eff_size));
            ea_c = ceau_align(upd_val, word_acc);
            mem_c = 1'b1;
            upd_en = take;
         end
         AM_ABS8: begin
            ea_c = {ABS8_PAGE, i_byte2};
            mem_c = 1'b1;
         end
         AM_ABS16: begin
            // Jumps align their target; word moves align too.
            ea_c = ceau_align(i_word2, word_acc || (i_class == IC_JUMP));
            mem_c = (i_class != IC_JUMP);
            tgt_c = (i_class == IC_JUMP);
         end
         AM_IMM8: opnd_c = {8'h00, i_byte2};
         AM_IMM16: opnd_c = i_word2;
         AM_PC_REL: begin
            ea_c = ceau_align(pc_sum, 1'b1);
            tgt_c = 1'b1;
         end
         AM_MEM_IND: begin
            ea_c = {MEMIND_PAGE, i_byte2[7:1], 1'b0};
            fetch_c = 1'b1;
         end
         AM_BIT_IMM3: opnd_c = {13'h0000, bit_c};
         AM_BIT_REG: begin
            // Bit number from low three bits of the chosen byte register.
            bit_c = i_reg_low ? rd_b[2:0] : rd_b[10:8];
            opnd_c = {13'h0000, bit_c};
         end
         AM_SMALL_IMM: opnd_c = i_small_two ? SMALL_IMM_TWO : SMALL_IMM_ONE;
         default: opnd_c = '0;
      endcase
   end

   // -------------------------------------------------------------
   // Sequencer and output registers
   // -------------------------------------------------------------
   logic rd_reg, rd_next;
   logic [15:0] maddr_reg, maddr_next;
   logic done_reg, done_next;
   logic ill_reg, ill_next;
   logic mem_reg, mem_next;
   logic tgt_reg, tgt_next;
   logic [15:0] ea_reg, ea_next;
   logic [15:0] op_reg, op_next;
   logic [2:0] bit_reg, bit_next;

   always_comb begin
      state_next = state_reg;
      rd_next = 1'b0;
      maddr_next = maddr_reg;
      done_next = 1'b0;
      ill_next = ill_reg;
      mem_next = mem_reg;
      tgt_next = tgt_reg;
      ea_next = ea_reg;
      op_next = op_reg;
      bit_next = bit_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (i_req) begin
               ill_next = !legal;
               // A refused request reports neither an operand address nor a target.
               mem_next = mem_c && legal;
               tgt_next = tgt_c && legal;
               op_next = opnd_c;
               bit_next = bit_c;
               ea_next = ea_c;
               if (fetch_c && legal) begin
                  // Stored pointer is fetched before the target is known.
                  state_next = ST_FETCH;
                  rd_next = 1'b1;
                  maddr_next = ea_c;
               end else begin
                  done_next = 1'b1;
               end
            end
         end
         ST_FETCH: begin
            // The read strobe stands one cycle; the answer is awaited next.
            state_next = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_mem_rvalid) begin
               ea_next = ceau_align(i_mem_rdata, 1'b1);
               tgt_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
         rd_reg <= 1'b0;
         maddr_reg <= '0;
         done_reg <= 1'b0;
         ill_reg <= 1'b0;
         mem_reg <= 1'b0;
         tgt_reg <= 1'b0;
         ea_reg <= '0;
         op_reg <= '0;
         bit_reg <= '0;
      end else begin
         state_reg <= state_next;
         rd_reg <= rd_next;
         maddr_reg <= maddr_next;
         done_reg <= done_next;
         ill_reg <= ill_next;
         mem_reg <= mem_next;
         tgt_reg <= tgt_next;
         ea_reg <= ea_next;
         op_reg <= op_next;
         bit_reg <= bit_next;
      end
   end

   assign o_mem_rd = rd_reg;
   assign o_mem_addr = maddr_reg;
   assign o_done = done_reg;
   assign o_illegal = ill_reg;
   assign o_is_mem = mem_reg;
   assign o_is_target = tgt_reg;
   assign o_ea = ea_reg;
   assign o_operand = op_reg;
   assign o_bit_num = bit_reg;
endmodule

// ==== tb.sv ====
// Self-checking bench of the effective-address unit: table of modes, then awkward cases.
// Assumes one 100 MHz clock and that the bench answers pointer fetches itself.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
   import ceau_pkg::*;
   typedef struct {ceau_class_t c; ceau_mode_t m; ceau_size_t s; logic [2:0] x; logic f;
      logic [15:0] im; logic [15:0] rv; logic [1:0] k; logic [15:0] e;} ceau_tb_row_t;
   logic i_clk, i_rstn, i_req, i_reg_low, i_small_two, i_bit_from_byte4, i_wr_en;
   logic i_mem_rvalid = 1'b0;
   logic [15:0] i_mem_rdata = 16'h0000;
   ceau_class_t i_class;
   ceau_mode_t i_mode;
   ceau_size_t i_size;
   logic [2:0] i_reg_idx, i_wr_idx, o_bit_num;
   logic [7:0] i_byte2;
   logic [15:0] i_word2, i_pc, i_wr_data, o_mem_addr, o_ea, o_operand, maddr;
   logic o_mem_rd, o_done, o_illegal, o_is_mem, o_is_target;
   logic [1:0] rv_pipe = 2'h0;
   int miscompares = 0;
   int check_count = 0;
   // Kind: 0 address, 1 operand, 2 bit number, 3 refused.
   ceau_tb_row_t rows [24] = '{
      '{IC_BYTE_MOVE, AM_REG_DIRECT, SZ_BYTE, 3'h1, 1'b1, '0, 16'h1234, 2'h1, 16'h0034},
      '{IC_WORD_ALU, AM_REG_DIRECT, SZ_WORD, 3'h2, 1'b0, '0, 16'hBEEF, 2'h1, 16'hBEEF},
      '{IC_BYTE_MOVE, AM_REG_INDIRECT, SZ_BYTE, 3'h3, 1'b0, '0, 16'h1235, 2'h0, 16'h1235},
      '{IC_BYTE_MOVE, AM_DISP16, SZ_BYTE, 3'h4, 1'b0, 16'h0020, 16'hFFF0, 2'h0, 16'h0010},
      '{IC_WORD_MOVE, AM_DISP16, SZ_WORD, 3'h4, 1'b0, 16'h4, 16'h1000, 2'h0, 16'h1004},
      '{IC_BYTE_MOVE, AM_POST_INC, SZ_BYTE, 3'h5, 1'b0, '0, 16'hFFFF, 2'h0, 16'hFFFF},
      '{IC_WORD_MOVE, AM_POST_INC, SZ_WORD, 3'h5, 1'b0, '0, 16'h1001, 2'h0, 16'h1000},
      '{IC_BYTE_MOVE, AM_PRE_DEC, SZ_BYTE, 3'h6, 1'b0, '0, 16'h0000, 2'h0, 16'hFFFF},
      '{IC_WORD_MOVE, AM_PRE_DEC, SZ_WORD, 3'h6, 1'b0, '0, 16'h2000, 2'h0, 16'h1FFE},
      '{IC_PUSH, AM_PRE_DEC, SZ_WORD, 3'h2, 1'b0, '0, 16'h2000, 2'h0, 16'h1FFE},
      '{IC_POP, AM_POST_INC, SZ_WORD, 3'h2, 1'b0, '0, 16'h3000, 2'h0, 16'h3000},
      '{IC_BIT_OTHER, AM_ABS8, SZ_BYTE, '0, 1'b0, 16'h0034, '0, 2'h0, 16'hFF34},
      '{IC_JUMP, AM_ABS16, SZ_WORD, '0, 1'b0, 16'h4568, '0, 2'h0, 16'h4568},
      '{IC_BYTE_MOVE, AM_IMM8, SZ_BYTE, '0, 1'b0, 16'h00A5, '0, 2'h1, 16'h00A5},
      '{IC_WORD_MOVE, AM_IMM16, SZ_WORD, '0, 1'b0, 16'hC3D2, '0, 2'h1, 16'hC3D2},
      '{IC_SMALL_ADDSUB, AM_SMALL_IMM, SZ_WORD, '0, 1'b1, '0, '0, 2'h1, 16'h0002},
      '{IC_BIT_OTHER, AM_BIT_IMM3, SZ_BYTE, '0, 1'b1, 16'h0050, '0, 2'h2, 16'h0005},
      '{IC_BRANCH, AM_PC_REL, SZ_BYTE, '0, 1'b0, 16'h00FF, 16'h0100, 2'h0, 16'h00FE},
      '{IC_BRANCH, AM_PC_REL, SZ_BYTE, '0, 1'b0, 16'h0080, 16'h0010, 2'h0, 16'hFF90},
      '{IC_ALU_BYTE_IMM, AM_IMM8, SZ_BYTE, '0, 1'b0, 16'h0011, '0, 2'h1, 16'h0011},
      '{IC_ALU_OTHER, AM_IMM8, SZ_BYTE, '0, 1'b0, '0, '0, 2'h3, '0},
      '{IC_BYTE_MOVE, AM_PC_REL, SZ_BYTE, '0, 1'b0, '0, '0, 2'h3, '0},
      '{IC_BIT_SCTT, AM_BIT_REG, SZ_BYTE, 3'h1, 1'b0, '0, 16'h0E5A, 2'h2, 16'h0006},
      '{IC_WORD_MOVE, AM_MEM_IND, SZ_WORD, '0, 1'b0, '0, '0, 2'h3, '0}};

   ceau_top u_ceau_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_class(i_class),
      .i_mode(i_mode), .i_size(i_size), .i_reg_idx(i_reg_idx), .i_reg_low(i_reg_low),
      .i_byte2(i_byte2), .i_word2(i_word2), .i_small_two(i_small_two),
      .i_bit_from_byte4(i_bit_from_byte4), .i_pc(i_pc), .i_wr_en(i_wr_en),
      .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .o_mem_rd(o_mem_rd),
      .o_mem_addr(o_mem_addr), .i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata),
      .o_done(o_done), .o_illegal(o_illegal), .o_is_mem(o_is_mem),
      .o_is_target(o_is_target), .o_ea(o_ea), .o_operand(o_operand), .o_bit_num(o_bit_num));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Pointer memory answers three cycles late; the data bus churns while idle.
   always @(posedge i_clk) begin
      rv_pipe <= {rv_pipe[0], o_mem_rd};
      i_mem_rvalid <= rv_pipe[1];
      i_mem_rdata <= rv_pipe[1] ? 16'h1235 : ~i_mem_rdata;
      if (o_mem_rd) maddr <= o_mem_addr;
   end
   task automatic wr(input logic [2:0] x, input logic [15:0] d);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_wr_idx <= x;
      i_wr_data <= d;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask
   task automatic issue(input ceau_class_t c, input ceau_mode_t m, input ceau_size_t s,
         input logic [2:0] x, input logic f, input logic [15:0] w, input logic [15:0] pc);
      int n;
      @(posedge i_clk);
      i_req <= 1'b1;
      i_class <= c;
      i_mode <= m;
      i_size <= s;
      i_reg_idx <= x;
      {i_reg_low, i_small_two, i_bit_from_byte4} <= {3{f}};
      {i_byte2, i_word2, i_pc} <= {w[7:0], w, pc};
      @(posedge i_clk);
      i_req <= 1'b0;
      #1;
      for (n = 0; n < 20 && o_done !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      `CHK("done", 1'b1, o_done)
   endtask
   task automatic run_row(input ceau_tb_row_t r);
      logic [2:0] ri;
      logic [15:0] st, er;
      logic tg;
      ri = (r.c == IC_PUSH || r.c == IC_POP) ? STACK_PTR_IDX : r.x;
      tg = (r.c == IC_BRANCH || r.c == IC_JUMP);
      st = (r.s == SZ_WORD) ? STEP_WORD : STEP_BYTE;
      er = (r.k == 2'h3) ? r.rv : (r.m == AM_POST_INC) ? r.rv + st :
         (r.m == AM_PRE_DEC) ? r.rv - st : r.rv;
      wr(ri, r.rv);
      issue(r.c, r.m, r.s, r.x, r.f, r.im, r.rv);
      `CHK("illegal", r.k == 2'h3, o_illegal)
      `CHK("memory flag", r.k == 2'h0 && !tg, o_is_mem)
      `CHK("target flag", r.k == 2'h0 && tg, o_is_target)
      case (r.k)
         2'h0: `CHK("address", r.e, o_ea)
         2'h1: `CHK("operand", r.e, o_operand)
         2'h2: `CHK("bit number", r.e[2:0], o_bit_num)
         default: ;
      endcase
      issue(IC_BYTE_MOVE, AM_REG_INDIRECT, SZ_BYTE, ri, 1'b0, '0, '0);
      `CHK("register", er, o_ea)
   endtask
   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      {i_rstn, i_req, i_wr_en, i_reg_low, i_small_two, i_bit_from_byte4} = '0;
      i_class = IC_BYTE_MOVE;
      i_mode = AM_REG_DIRECT;
      i_size = SZ_BYTE;
      {i_reg_idx, i_wr_idx, i_byte2, i_word2, i_pc, i_wr_data} = '0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("table row %0d finished", i);
      end
      issue(IC_JUMP, AM_MEM_IND, SZ_WORD, 3'h0, 1'b0, 16'h0011, '0);
      `CHK("pointer address", 16'h0010, maddr)
      `CHK("fetched target", 16'h1234, o_ea)
      `CHK("target flag", 1'b1, o_is_target)
      $display("pointer fetch test finished");
      wr(3'h3, 16'h5555);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      #1;
      `CHK("result in reset", 1'b0, o_done)
      `CHK("address in reset", 16'h0000, o_ea)
      `CHK("target in reset", 1'b0, o_is_target)
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      issue(IC_BYTE_MOVE, AM_REG_INDIRECT, SZ_BYTE, 3'h3, 1'b0, '0, '0);
      `CHK("register after reset", 16'h0000, o_ea)
      $display("reset test finished");
      give_verdict();
   end
endmodule
